// File: hdl/epm_cfg.svh
/*
 * Constants for the E1 performance monitor: register offsets,
 * field positions, indirect indices, counter widths and timing.
 * Assumes it is included by bare name from design files only.
 */
`ifndef EPM_CFG_SVH
`define EPM_CFG_SVH

// Direct register offsets on the 8-bit register port
`define EPM_OFS_INDEX     8'h0e
`define EPM_OFS_RDATA     8'h0f
`define EPM_OFS_CTRL      8'hc2
`define EPM_OFS_EN_LO     8'hc3
`define EPM_OFS_EN_HI     8'hc4
`define EPM_OFS_FLAG_LO   8'hc5
`define EPM_OFS_FLAG_HI   8'hc6
`define EPM_OFS_CLR_LO    8'hc7
`define EPM_OFS_CLR_HI    8'hc8

// Control register fields
`define EPM_CTRL_MANUAL   0
`define EPM_CTRL_AUTO     1

// Index register field width and the lone sync-loss index
`define EPM_IDX_W         4
`define EPM_IDX_SYNC      4'h5

// Counter count and widths, in channel order
`define EPM_NCH           9
`define EPM_CW            16
`define EPM_W_CRC4        10
`define EPM_W_FRAMING     12
`define EPM_W_ALIGN       3
`define EPM_W_PATTERN     16
`define EPM_W_LINE        16
`define EPM_W_NAT_CRC     10
`define EPM_W_FAR_BLOCK   10
`define EPM_W_NAT_FAR     10
`define EPM_W_SYNC        5

// Auto transfer interval and clock period
`define EPM_AUTO_PERIOD_MS 1000
`define EPM_CLK_PERIOD_NS  100
`define EPM_SEC_CYCLES ((`EPM_AUTO_PERIOD_MS * 1000000) / `EPM_CLK_PERIOD_NS)
`define EPM_SEC_CNT_W      24

`endif

// File: hdl/epm_pkg.sv
/*
 * Types shared by the E1 performance monitor and its bench.
 * Assumes epm_cfg.svh supplies the widths.
 */
`include "epm_cfg.svh"

package epm_pkg;

  // One error pulse per monitored event, first field is the top bit
  typedef struct packed {
    logic sync_loss;       // Loss of basic frame sync
    logic nat_far_block;   // National-bit far end block error
    logic far_block;       // Far end block error
    logic nat_crc;         // National-bit CRC error
    logic line_violation;  // Bipolar or HDB3 code violation
    logic pattern_error;   // Pattern receiver bit error
    logic align_change;    // New alignment position differs
    logic framing;         // FAS/NFAS bit or pattern error
    logic crc4;            // CRC-4 error
  } epm_events_t;

  // Register port request as one bundle
  typedef struct packed {
    logic [7:0] addr;      // Register offset
    logic [7:0] wdata;     // Write data
    logic       wr;        // Write strobe
    logic       rd;        // Read strobe
  } epm_bus_req_t;

endpackage

// File: hdl/epm_monitor.sv
/*
 * E1 performance monitor: nine error counters, snapshot registers
 * read through an index/data pair, overflow flags and interrupt.
 * Assumes event inputs are one-cycle pulses synchronous to
 * core_clk_i and a register master that never needs wait states.
 */
// Overview of operation
// RULE1 - Auto bit copies counters every second
// RULE2 - Manual bit rising edge copies counters
// RULE3 - Counters clear after every transfer
// RULE4 - Event during transfer counts in new interval
// RULE5 - 4-bit index selects byte shown
// RULE6 - Overflow sets flag; enabled flag interrupts
// RULE7 - 16-bit line violation counter, indices 9/8
// RULE8 - 12-bit framing error counter, indices 3/2
// RULE9 - 10-bit CRC-4 error counter, indices 1/0
// RULE10 - 10-bit far block counter, indices D/C
// RULE11 - 3-bit alignment change counter, index 4
// RULE12 - 5-bit sync loss counter, index 5
// RULE13 - 16-bit pattern error counter, indices 7/6
// RULE14 - 10-bit national far block counter, F/E
// RULE15 - 10-bit national CRC counter, B/A
// RULE16 - Nine flags split over C6 and C5
// RULE17 - Nine enables split over C4 and C3
// RULE18 - Index written at 0E, byte read 0F
// RULE19 - Flags stick until written one; irq follows
`timescale 1ns/1ps
`include "epm_cfg.svh"

module epm_monitor #(
  parameter int unsigned SEC_CYCLES = `EPM_SEC_CYCLES  // Cycles per second
) (
  input  wire logic                core_clk_i,   // 10 MHz clock
  input  wire logic                rstn_i,       // Async reset, low
  input  wire epm_pkg::epm_bus_req_t bus_i,      // Register request
  input  wire epm_pkg::epm_events_t  events_i,   // Error pulses
  output logic [7:0]               rdata_o,      // Read data
  output logic                     irq_o,        // Interrupt level
  output logic                     transfer_o    // Snapshot taken
);

  // Channel widths in channel order (crc4 is channel 0)
  function automatic int chan_width(input int ch);
    int w;
    w = `EPM_W_SYNC;
    case (ch)
      0: w = `EPM_W_CRC4;
      1: w = `EPM_W_FRAMING;
      2: w = `EPM_W_ALIGN;
      3: w = `EPM_W_PATTERN;
      4: w = `EPM_W_LINE;
      5: w = `EPM_W_NAT_CRC;
      6: w = `EPM_W_FAR_BLOCK;
      7: w = `EPM_W_NAT_FAR;
      default: w = `EPM_W_SYNC;
    endcase
    return w;
  endfunction

  // Flat view of the event bundle, bit n feeds channel n
  logic [`EPM_NCH-1:0]   ev;
  assign ev = events_i;

  // Software visible state
  logic [`EPM_IDX_W-1:0] index_ff;     // Indirect index
  logic                  manual_ff;    // Manual trigger bit
  logic                  auto_ff;      // Auto transfer enable
  logic [`EPM_NCH-1:0]   enable_ff;    // Overflow enables
  logic [`EPM_NCH-1:0]   flag_ff;      // Sticky overflow flags
  logic [`EPM_NCH-1:0]   nxt_flag;     // Next flag value
  logic [`EPM_NCH-1:0]   clr;          // Clear-by-one mask
  logic [`EPM_NCH-1:0]   ovf;          // Overflow this cycle

  // Counters and snapshots, all held 16 bits wide
  logic [`EPM_CW-1:0]    cnt_ff  [`EPM_NCH];  // Live counts
  logic [`EPM_CW-1:0]    snap_ff [`EPM_NCH];  // Transferred counts

  // One second timer
  logic [`EPM_SEC_CNT_W-1:0] sec_cnt_ff;      // Cycle count
  logic                      sec_tick;        // Second elapsed

  // Transfer decode
  logic                  wr_ctrl;      // Control register write
  logic                  manual_rise;  // Trigger 0 to 1
  logic                  xfer;         // Copy and restart

  // Read path
  logic [7:0]            rd_mux;       // Selected read value
  logic [7:0]            ind_byte;     // Selected indirect byte

  // Register writes to the control offset
  assign wr_ctrl = bus_i.wr && (bus_i.addr == `EPM_OFS_CTRL);

  // Only a fresh 0 to 1 on the trigger starts a copy; a repeated
  // write of one is ignored until software writes zero first
  assign manual_rise = wr_ctrl && bus_i.wdata[`EPM_CTRL_MANUAL]
                       && !manual_ff;                        // [RULE2]

  // The timer only ticks while auto transfer is enabled
  assign sec_tick = auto_ff &&
                    (sec_cnt_ff == `EPM_SEC_CNT_W'(SEC_CYCLES - 1));

  // Either source copies; manual works whatever auto holds
  assign xfer = sec_tick || manual_rise;                     // [RULE1] [RULE2]

  // Index register, only the low nibble is kept
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      index_ff <= '0;
    end else if (bus_i.wr && (bus_i.addr == `EPM_OFS_INDEX)) begin
      index_ff <= bus_i.wdata[`EPM_IDX_W-1:0];               // [RULE5] [RULE18]
    end
  end

  // Control register bits
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      manual_ff <= 1'b0;
      auto_ff   <= 1'b0;
    end else if (wr_ctrl) begin
      manual_ff <= bus_i.wdata[`EPM_CTRL_MANUAL];
      auto_ff   <= bus_i.wdata[`EPM_CTRL_AUTO];              // [RULE1]
    end
  end

  // Enable registers: eight in the low byte, sync loss high
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_ff <= '0;
    end else if (bus_i.wr) begin
      if (bus_i.addr == `EPM_OFS_EN_LO) begin
        enable_ff[7:0] <= bus_i.wdata;                       // [RULE17]
      end else if (bus_i.addr == `EPM_OFS_EN_HI) begin
        enable_ff[8] <= bus_i.wdata[0];                      // [RULE17]
      end
    end
  end

  // One second timer; restarts on disable and after any transfer
  // so a manual copy also opens a full fresh interval
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sec_cnt_ff <= '0;
    end else if (!auto_ff || xfer) begin
      sec_cnt_ff <= '0;
    end else begin
      sec_cnt_ff <= sec_cnt_ff + 1'b1;                       // [RULE1]
    end
  end

  // Per-channel counter, overflow detect and snapshot
  for (genvar g = 0; g < `EPM_NCH; g++) begin : g_ch
    localparam int          W   = chan_width(g);
    localparam logic [31:0] M32 = (32'h1 << W) - 32'h1;
    localparam logic [`EPM_CW-1:0] MAX = M32[`EPM_CW-1:0];

    // Wrap at the channel's own width; a wrap during a transfer
    // cannot happen because the count restarts instead
    assign ovf[g] = ev[g] && !xfer && (cnt_ff[g] == MAX);    // [RULE6]

    // Live count; an event in the transfer cycle opens the new
    // interval at one so it is never lost
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        cnt_ff[g] <= '0;
      end else if (xfer) begin
        cnt_ff[g] <= `EPM_CW'(ev[g]);                        // [RULE3] [RULE4]
      end else if (ev[g]) begin
        if (cnt_ff[g] == MAX) begin
          cnt_ff[g] <= '0;
        end else begin
          cnt_ff[g] <= cnt_ff[g] + 1'b1;  // [RULE7] [RULE8] [RULE9] [RULE10]
        end                               // [RULE11] [RULE12] [RULE13]
      end                                 // [RULE14] [RULE15]
    end

    // Snapshot copied on every transfer
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        snap_ff[g] <= '0;
      end else if (xfer) begin
        snap_ff[g] <= cnt_ff[g];                             // [RULE1] [RULE2]
      end
    end
  end

  // Clear masks from the write-only clear registers
  always_comb begin
    clr = '0;
    if (bus_i.wr && (bus_i.addr == `EPM_OFS_CLR_LO)) begin
      clr[7:0] = bus_i.wdata;
    end else if (bus_i.wr && (bus_i.addr == `EPM_OFS_CLR_HI)) begin
      clr[8] = bus_i.wdata[0];
    end
  end

  // A new overflow beats a clear in the same cycle
  assign nxt_flag = (flag_ff & ~clr) | ovf;                  // [RULE19]

  // Sticky overflow flags
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flag_ff <= '0;
    end else begin
      flag_ff <= nxt_flag;                                   // [RULE6] [RULE19]
    end
  end

  // Interrupt level; one cycle behind the flags, registered so
  // the pin never glitches on decode
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(flag_ff & enable_ff);                       // [RULE6] [RULE19]
    end
  end

  // Transfer pulse for the outside world, one cycle after copy
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      transfer_o <= 1'b0;
    end else begin
      transfer_o <= xfer;
    end
  end

  // Indirect byte select: pairs map to channel index by the upper
  // three index bits; index 5 is the lone sync-loss byte
  always_comb begin
    ind_byte = '0;
    if (index_ff == `EPM_IDX_SYNC) begin
      ind_byte = snap_ff[8][7:0];                            // [RULE12]
    end else if (index_ff[0]) begin
      ind_byte = snap_ff[index_ff[3:1]][15:8];               // [RULE5]
    end else begin
      ind_byte = snap_ff[index_ff[3:1]][7:0];                // [RULE5]
    end
  end

  // Read decode; unmapped and write-only offsets read zero
  always_comb begin
    rd_mux = '0;
    if (bus_i.addr == `EPM_OFS_INDEX) begin
      rd_mux = {{(8-`EPM_IDX_W){1'b0}}, index_ff};
    end else if (bus_i.addr == `EPM_OFS_RDATA) begin
      rd_mux = ind_byte;                                     // [RULE18]
    end else if (bus_i.addr == `EPM_OFS_CTRL) begin
      rd_mux = {6'h0, auto_ff, manual_ff};
    end else if (bus_i.addr == `EPM_OFS_EN_LO) begin
      rd_mux = enable_ff[7:0];
    end else if (bus_i.addr == `EPM_OFS_EN_HI) begin
      rd_mux = {7'h0, enable_ff[8]};
    end else if (bus_i.addr == `EPM_OFS_FLAG_LO) begin
      rd_mux = flag_ff[7:0];                                 // [RULE16]
    end else if (bus_i.addr == `EPM_OFS_FLAG_HI) begin
      rd_mux = {7'h0, flag_ff[8]};                           // [RULE16]
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o <= '0;
    end else if (bus_i.rd) begin
      rdata_o <= rd_mux;
    end else begin
      rdata_o <= '0;
    end
  end

endmodule

// File: tb/epm_monitor_asserts.sv
/* Port checker for epm_monitor.
   Assumes bind to every epm_monitor instance. */
`timescale 1ns/1ps
module epm_monitor_asserts #(
  parameter int unsigned SEC_CYCLES = 50
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  rstn_i,
  input  wire epm_pkg::epm_bus_req_t bus_i,
  input  wire epm_pkg::epm_events_t  events_i,
  input  wire logic [7:0]            rdata_o,
  input  wire logic                  irq_o,
  input  wire logic                  transfer_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [3:0] idx_ff; // Shadow index
  logic [8:0] en_ff;  // Shadow enables
  logic [1:0] ctl_ff; // Shadow control
  wire trig = bus_i.wr && bus_i.addr == 8'hc2 && bus_i.wdata[0] && !ctl_ff[0];
  wire wirq = bus_i.wr && bus_i.addr inside {8'hc3, 8'hc4, 8'hc7, 8'hc8};
  // Shadows follow software writes
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      idx_ff <= 4'h0;
      en_ff  <= 9'h000;
      ctl_ff <= 2'h0;
    end else if (bus_i.wr) begin
      if (bus_i.addr == 8'h0e) idx_ff <= bus_i.wdata[3:0];
      if (bus_i.addr == 8'hc2) ctl_ff <= bus_i.wdata[1:0];
      if (bus_i.addr == 8'hc3) en_ff[7:0] <= bus_i.wdata;
      if (bus_i.addr == 8'hc4) en_ff[8] <= bus_i.wdata[0];
    end
  end
  a_manual_xfer: assert property (trig |=> transfer_o)
    else $error("manual edge gave no transfer");
  a_xfer_cause: assert property (transfer_o |-> $past(trig) || $past(ctl_ff[1]))
    else $error("transfer without cause");
  a_xfer_pulse: assert property (transfer_o |=> !transfer_o)
    else $error("transfer pulse too long");
  a_rdata_idle: assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00)
    else $error("read data outside read slot");
  a_index_back: assert property (bus_i.rd && bus_i.addr == 8'h0e |=> rdata_o == {4'h0, idx_ff})
    else $error("index readback wrong");
  a_ctrl_back: assert property (bus_i.rd && bus_i.addr == 8'hc2 |=> rdata_o == {6'h00, ctl_ff})
    else $error("control readback wrong");
  a_enable_back: assert property (bus_i.rd && bus_i.addr == 8'hc3 |=> rdata_o == en_ff[7:0])
    else $error("enable readback wrong");
  a_irq_masked: assert property (en_ff == 9'h000 [*3] |-> !irq_o)
    else $error("irq with all enables off");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(wirq) || $past(wirq, 2))
    else $error("irq dropped without clear");
  a_unmapped_zero: assert property (bus_i.rd && !(bus_i.addr inside {8'h0e, 8'h0f,
      [8'hc2:8'hc6]}) |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind epm_monitor epm_monitor_asserts #(.SEC_CYCLES(SEC_CYCLES)) u_asserts (
  .core_clk_i(core_clk_i), .rstn_i(rstn_i), .bus_i(bus_i), .events_i(events_i),
  .rdata_o(rdata_o), .irq_o(irq_o), .transfer_o(transfer_o));

// File: tb/tb.sv
/* Self-checking bench for epm_monitor with a cycle model.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module tb;
  localparam int SEC = 50;                     // Short second for sim
  localparam int W[9] = '{10, 12, 3, 16, 16, 10, 10, 10, 5};
  localparam int LO[9] = '{0, 2, 4, 6, 8, 10, 12, 14, 5};
  localparam logic [7:0] RA[9] = '{8'h0e, 8'h0f, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'h10};
  logic clk, rstn, irq, xfer, xf, xf_m, irq_m;
  epm_pkg::epm_bus_req_t bus;
  epm_pkg::epm_events_t  ev;
  logic [7:0]  rdata;
  logic [8:0]  fl, ovp, en, clr;
  logic [1:0]  ctl;
  logic [15:0] lf;
  int cnt[9], snap[9], tmr, n_mismatch, tests_run;
  epm_monitor #(.SEC_CYCLES(SEC)) dut (.core_clk_i(clk), .rstn_i(rstn), .bus_i(bus),
    .events_i(ev), .rdata_o(rdata), .irq_o(irq), .transfer_o(xfer));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  function automatic logic [15:0] nxt(logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // Expected indirect byte from the model snapshot
  function automatic logic [7:0] ebyte(int i);
    foreach (LO[c]) begin
      if (i == LO[c]) return snap[c][7:0];
      if (i == LO[c] + 1 && c != 2 && c != 8) return snap[c][15:8];
    end
    return 8'h00;
  endfunction
  task automatic check(logic [15:0] got, logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk) begin bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1; end
    @(posedge clk) bus.wr <= 1'b0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk) begin bus.addr <= a; bus.rd <= 1'b1; end
    @(posedge clk) bus.rd <= 1'b0;
    #1 check(rdata, e);
  endtask
  task automatic rd_all();
    for (int i = 0; i < 16; i++) begin
      wr(8'h0e, 8'(i));
      rd(8'h0f, ebyte(i));
    end
  endtask
  task automatic rnd(int n);
    repeat (n) @(posedge clk) begin lf = nxt(lf); ev <= lf[8:0]; end
    @(posedge clk) ev <= '0;
  endtask
  // Cycle model of counters, snapshots, flags and timer
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      foreach (cnt[c]) begin cnt[c] = 0; snap[c] = 0; end
      {fl, ovp, en, ctl, tmr, xf_m, irq_m} = '0;
    end else begin
      xf = (bus.wr && bus.addr == 8'hc2 && bus.wdata[0] && !ctl[0]) || (ctl[1] && tmr == SEC - 1);
      irq_m = |(fl & en);
      clr = {bus.wr && bus.addr == 8'hc8 && bus.wdata[0], (bus.wr && bus.addr == 8'hc7) ? bus.wdata : 8'h00};
      ovp = '0;
      foreach (cnt[c]) begin
        if (xf) begin snap[c] = cnt[c]; cnt[c] = ev[c]; end
        else if (ev[c] && cnt[c] == (1 << W[c]) - 1) begin cnt[c] = 0; ovp[c] = 1'b1; end
        else cnt[c] += ev[c];
      end
      fl = (fl & ~clr) | ovp;
      tmr = (xf || !ctl[1]) ? 0 : tmr + 1;
      xf_m = xf;
      if (bus.wr && bus.addr == 8'hc2) ctl = bus.wdata[1:0];
      if (bus.wr && bus.addr == 8'hc3) en[7:0] = bus.wdata;
      if (bus.wr && bus.addr == 8'hc4) en[8] = bus.wdata[0];
    end
  end
  // Transfer and interrupt compared every cycle
  always @(negedge clk) if (rstn) begin
    check(xfer, xf_m);
    check(irq, irq_m);
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #(100 * 20000);
    n_mismatch++;
    $display("[ERR] %0t watchdog expired", $time);
    conclude();
  end
  initial begin
    {rstn, bus, ev, n_mismatch, tests_run} = '0;
    lf = 16'h0029;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    foreach (RA[k]) rd(RA[k], 8'h00);
    $display("reset values done");
    rnd(300);
    // Manual trigger with every event in the same cycle
    @(posedge clk) begin ev <= '1; bus.addr <= 8'hc2; bus.wdata <= 8'h01; bus.wr <= 1'b1; end
    @(posedge clk) begin ev <= '0; bus.wr <= 1'b0; end
    wr(8'hc2, 8'h00);
    rd_all();
    wr(8'hc2, 8'h01);
    wr(8'hc2, 8'h00);
    rd_all();
    $display("manual transfer done");
    // Eight align pulses wrap the 3-bit counter
    repeat (8) @(posedge clk) ev <= 9'h004;
    @(posedge clk) ev <= '0;
    wr(8'hc5, 8'hff);
    rd(8'hc5, fl[7:0]);
    rd(8'hc6, {7'h00, fl[8]});
    wr(8'hc3, 8'hff);
    wr(8'hc4, 8'h01);
    rd(8'hc4, 8'h01);
    wr(8'hc7, 8'hff);
    wr(8'hc8, 8'h01);
    rd(8'hc5, 8'h00);
    $display("overflow and irq done");
    wr(8'hc2, 8'h02);
    rnd(SEC * 3);
    wr(8'hc2, 8'h00);
    rd_all();
    $display("auto transfer done");
    conclude();
  end
endmodule
